// ==== hdl/cdap_counter_data_access_port.sv ====
// Counter group data access port with three counters and command register
// Notes on behaviour
// - Three counters; counters 1 and 2 give update pulses pacing waveform output.
// - Counter 3 output may clock counters 1 and 2 instead.
// - Data registers are 8 bits; 16-bit values move as two byte accesses.
// - Writing a data register loads starting count for that counter.
// - Read gives live count unless something is latched, then latched data.
// - Latched count or status holds unchanged until read out.
// - Later latch or read-back commands leave an unread count or status latch unchanged.
// - Latched 16-bit count reads low byte first, then high byte, unless a latch command follows an unpaired live low-byte read.
// - Status byte reads first, then count bytes, regardless of latch order.
// - Counter 1 data at offset 06 only while group select is clear.
// - Counter 2 data at offset 07 only while group select is clear.
// - Command bits 7-6 select counter 1, 2, 3, or read-back.
// - Command bits 5-4: latch, low only, high only, low then high.
// - Count latch captures current count for next read.
// - Decimal select bit chooses BCD counting, else 16-bit binary.
`timescale 1ns/1ns
`default_nettype none
module cdap_counter_data_access_port (
    input wire logic clock,
    input wire logic reset,
    input wire cdap_pkg::cdap_host_req_t host_req,
    input wire logic register_group_select,
    input wire logic [2:0] count_clock,
    input wire logic [2:0] count_gate,
    output logic [7:0] read_data,
    output logic [2:0] counter_out,
    output logic update_one,
    output logic update_two
);
    import cdap_pkg::*;

    cdap_chan_t ch_r [3];
    cdap_chan_t ch_nxt [3];
    logic [7:0] read_data_r, read_data_nxt;
    logic [2:0] out_r, out_nxt;
    logic [2:0] clk_prev_r, clk_prev_nxt;
    logic alt_clock_r, alt_clock_nxt;

    // Decoded data register index; group select hides 06 and 07
    function automatic logic [1:0] data_index(input logic [3:0] a, input logic grp);
        data_index = 2'h3;
        if (a == CDAP_OFF_CNT1 && !grp) data_index = 2'h0;
        if (a == CDAP_OFF_CNT2 && !grp) data_index = 2'h1;
        if (a == CDAP_OFF_CNT3) data_index = 2'h2;
    endfunction

    // One count step in binary or BCD
    function automatic logic [15:0] dec_step(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v - 16'h0001;
        if (bcd) begin
            r = v;
            for (int d = 0; d < 4; d++) begin
                if (r[d*4 +: 4] != 4'h0) begin
                    r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                    break;
                end
                r[d*4 +: 4] = 4'h9;
            end
        end
        dec_step = r;
    endfunction

    logic [1:0] idx;
    logic is_cmd;
    assign idx = data_index(host_req.addr, register_group_select);
    assign is_cmd = host_req.wr && host_req.addr == CDAP_OFF_CMD;

    // Next state of all three counters
    always_comb begin
        logic tick;
        logic hit;
        logic [15:0] loaded;
        logic [15:0] src;
        tick = 1'b0;
        src = 16'h0000;
        hit = 1'b0;
        loaded = 16'h0000;
        ch_nxt = ch_r;
        read_data_nxt = read_data_r;
        out_nxt = out_r;
        clk_prev_nxt = count_clock;
        alt_clock_nxt = out_r[2];
        for (int i = 0; i < 3; i++) begin
            // Counter three clocks the others when mode bit picks it
            if (i < 2 && ch_r[i].ctrl[CDAP_MODE_HI])
                tick = alt_clock_r && !out_r[2];
            else
                tick = clk_prev_r[i] && !count_clock[i];
            // Count down and pulse at terminal count
            if (tick && count_gate[i]) begin
                ch_nxt[i].count = dec_step(ch_r[i].count, ch_r[i].ctrl[CDAP_BCD_BIT]);
                out_nxt[i] = (ch_r[i].count == 16'h0001);
            end
            hit = (idx == 2'(i));
            if (is_cmd) begin
                if (host_req.data[CDAP_SEL_HI:CDAP_SEL_LO] == CDAP_SEL_READBACK) begin
                    if (host_req.data[i+1]) begin
                        if (!host_req.data[CDAP_RB_NCOUNT] && !ch_r[i].cnt_latched) begin
                            ch_nxt[i].latch = ch_r[i].count;
                            ch_nxt[i].cnt_latched = 1'b1;
                            ch_nxt[i].rd_ptr = 1'b0;
                        end
                        if (!host_req.data[CDAP_RB_NSTATUS] && !ch_r[i].st_latched) begin
                            ch_nxt[i].status = {out_r[i], 1'b0, ch_r[i].ctrl[5:0]};
                            ch_nxt[i].st_latched = 1'b1;
                        end
                    end
                end else if (host_req.data[CDAP_SEL_HI:CDAP_SEL_LO] == 2'(i)) begin
                    if (host_req.data[CDAP_ACC_HI:CDAP_ACC_LO] == CDAP_ACC_LATCH) begin
                        if (!ch_r[i].cnt_latched) begin
                            ch_nxt[i].latch = ch_r[i].count;
                            ch_nxt[i].cnt_latched = 1'b1;
                        end
                    end else begin
                        ch_nxt[i].ctrl = host_req.data;
                        ch_nxt[i].rd_ptr = 1'b0;
                        ch_nxt[i].wr_ptr = 1'b0;
                    end
                end
            end
            if (host_req.wr && hit) begin
                unique case (cdap_access_t'(ch_r[i].ctrl[CDAP_ACC_HI:CDAP_ACC_LO]))
                    CDAP_ACC_LSB: ch_nxt[i].count = {8'h00, host_req.data};
                    CDAP_ACC_MSB: ch_nxt[i].count = {host_req.data, 8'h00};
                    CDAP_ACC_BOTH: begin
                        // Two byte writes form one count
                        if (!ch_r[i].wr_ptr) begin
                            ch_nxt[i].low_hold = host_req.data;
                        end else begin
                            loaded = {host_req.data, ch_r[i].low_hold};
                            ch_nxt[i].count = loaded;
                        end
                        ch_nxt[i].wr_ptr = !ch_r[i].wr_ptr;
                    end
                    CDAP_ACC_LATCH: ch_nxt[i].wr_ptr = ch_r[i].wr_ptr;
                endcase
            end
            // Read path, status first then count
            if (host_req.rd && hit) begin
                if (ch_r[i].st_latched) begin
                    read_data_nxt = ch_r[i].status;
                    ch_nxt[i].st_latched = 1'b0;
                end else begin
                    src = ch_r[i].cnt_latched ? ch_r[i].latch : ch_r[i].count;
                    unique case (cdap_access_t'(ch_r[i].ctrl[CDAP_ACC_HI:CDAP_ACC_LO]))
                        CDAP_ACC_MSB: begin
                            read_data_nxt = src[15:8];
                            ch_nxt[i].cnt_latched = 1'b0;
                        end
                        CDAP_ACC_BOTH: begin
                            read_data_nxt = ch_r[i].rd_ptr ? src[15:8] : src[7:0];
                            // Latch released only after last byte
                            if (ch_r[i].rd_ptr) ch_nxt[i].cnt_latched = 1'b0;
                            ch_nxt[i].rd_ptr = !ch_r[i].rd_ptr;
                        end
                        default: begin
                            read_data_nxt = src[7:0];
                            ch_nxt[i].cnt_latched = 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Register stage
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                ch_r[i] <= '0;
            end
            read_data_r <= 8'h00;
            out_r <= 3'h0;
            clk_prev_r <= 3'h0;
            alt_clock_r <= 1'b0;
        end else begin
            ch_r <= ch_nxt;
            read_data_r <= read_data_nxt;
            out_r <= out_nxt;
            clk_prev_r <= clk_prev_nxt;
            alt_clock_r <= alt_clock_nxt;
        end
    end

    assign read_data = read_data_r;
    assign counter_out = out_r;
    // Update pulses come from registered outputs
    assign update_one = out_r[0];
    assign update_two = out_r[1];

    // Checks
    a_latch_hold: assert property (@(posedge clock) disable iff (reset)
        ch_r[0].cnt_latched && !host_req.rd |=> $stable(ch_r[0].latch))
        else $error("latched count changed before read");
    a_first_only: assert property (@(posedge clock) disable iff (reset)
        ch_r[1].cnt_latched && is_cmd |=> ch_r[1].latch == $past(ch_r[1].latch))
        else $error("second latch overwrote first");
    a_status_first: assert property (@(posedge clock) disable iff (reset)
        ch_r[1].st_latched && host_req.rd && idx == 2'h1 |=> read_data_r == $past(ch_r[1].status))
        else $error("status not returned first");
    a_group_hide: assert property (@(posedge clock) disable iff (reset)
        register_group_select && host_req.wr && host_req.addr == CDAP_OFF_CNT1 |=> $stable(ch_r[0].count)
            || $past(count_gate[0]))
        else $error("counter one decoded with group select set");
    // Word latch must hand out its low byte first
    a_low_first: assert property (@(posedge clock) disable iff (reset)
        !ch_r[0].st_latched && ch_r[0].cnt_latched && !ch_r[0].rd_ptr && host_req.rd && idx == 2'h0
            && ch_r[0].ctrl[CDAP_ACC_HI:CDAP_ACC_LO] == CDAP_ACC_BOTH
            |=> read_data_r == $past(ch_r[0].latch[7:0]))
        else $error("latched word did not start with low byte");
    // A stale half word would pair with the wrong byte
    a_ptr_restart: assert property (@(posedge clock) disable iff (reset)
        is_cmd && host_req.data[CDAP_SEL_HI:CDAP_SEL_LO] == 2'h0
            && host_req.data[CDAP_ACC_HI:CDAP_ACC_LO] != CDAP_ACC_LATCH
            |=> !ch_r[0].rd_ptr && !ch_r[0].wr_ptr)
        else $error("byte pointers not back at low byte after command");
    c_latch_read: cover property (@(posedge clock) ch_r[0].cnt_latched ##1 host_req.rd);
    c_status_read: cover property (@(posedge clock) ch_r[1].st_latched && host_req.rd && idx == 2'h1);
    c_terminal: cover property (@(posedge clock) out_r[0]);
endmodule
`default_nettype wire

// ==== hdl/cdap_pkg.sv ====
// Package: constants and types for the counter data access port
`default_nettype none
package cdap_pkg;
    localparam logic [3:0] CDAP_OFF_CNT1 = 4'h6;
    localparam logic [3:0] CDAP_OFF_CNT2 = 4'h7;
    localparam logic [3:0] CDAP_OFF_CNT3 = 4'h8;
    localparam logic [3:0] CDAP_OFF_CMD = 4'h9;
    localparam int CDAP_SEL_HI = 7;
    localparam int CDAP_SEL_LO = 6;
    localparam int CDAP_ACC_HI = 5;
    localparam int CDAP_ACC_LO = 4;
    localparam int CDAP_MODE_HI = 3;
    localparam int CDAP_MODE_LO = 1;
    localparam int CDAP_BCD_BIT = 0;
    localparam int CDAP_RB_NCOUNT = 5;
    localparam int CDAP_RB_NSTATUS = 4;
    localparam logic [1:0] CDAP_SEL_READBACK = 2'h3;
    localparam logic [15:0] CDAP_COUNT_RESET = 16'h0000;
    localparam logic [7:0] CDAP_CTRL_RESET = 8'h00;

    typedef enum logic [1:0] {
        CDAP_ACC_LATCH = 2'b00,
        CDAP_ACC_LSB = 2'b01,
        CDAP_ACC_MSB = 2'b10,
        CDAP_ACC_BOTH = 2'b11
    } cdap_access_t;

    // Host access bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] data;
    } cdap_host_req_t;

    // Per-counter access state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [15:0] latch;
        logic cnt_latched;
        logic [7:0] status;
        logic st_latched;
        logic rd_ptr;
        logic wr_ptr;
        logic [7:0] low_hold;
    } cdap_chan_t;
endpackage
`default_nettype wire

// ==== testbench/cdap_host_model.sv ====
// Host processor model issuing byte cycles to the counter port
`timescale 1ns/1ns
`default_nettype none
module cdap_host_model
    import cdap_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] read_data,
    output var cdap_pkg::cdap_host_req_t host_req
);
    initial host_req = '0;
    // Strobe held over one rising edge; released bus shows inverted data
    task automatic cycle(input logic rd, input logic [3:0] addr, input logic [7:0] data);
        @(negedge clock);
        host_req = '{rd: rd, wr: !rd, addr: addr, data: data};
        @(negedge clock);
        host_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, data: ~data};
    endtask
    task automatic wr_byte(input logic [3:0] addr, input logic [7:0] data);
        cycle(1'b0, addr, data);
    endtask
    task automatic rd_byte(input logic [3:0] addr, output logic [7:0] q);
        cycle(1'b1, addr, 8'h00);
        q = read_data;
    endtask
    task automatic command(input logic [1:0] sel, input logic [1:0] acc, input logic [3:0] low);
        wr_byte(CDAP_OFF_CMD, {sel, acc, low});
    endtask
    // word as low then high byte
    task automatic wr_word(input logic [3:0] addr, input logic [15:0] w);
        wr_byte(addr, w[7:0]);
        wr_byte(addr, w[15:8]);
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_counter_data_access_port.sv ====
// Self-checking bench for the counter data access port
`timescale 1ns/1ns
`default_nettype none
module tb_counter_data_access_port;
    import cdap_pkg::*;
    logic clock, reset, register_group_select, update_one, update_two;
    logic [2:0] count_clock, count_gate, counter_out;
    logic [7:0] read_data, q;
    logic [31:0] seed;
    logic [15:0] w;
    cdap_host_req_t host_req;
    int errors, samples_checked;
    int exp_q[$];

    cdap_counter_data_access_port dut_u (.clock(clock), .reset(reset), .host_req(host_req),
        .register_group_select(register_group_select), .count_clock(count_clock),
        .count_gate(count_gate), .read_data(read_data), .counter_out(counter_out),
        .update_one(update_one), .update_two(update_two));
    cdap_host_model host_u (.clock(clock), .read_data(read_data), .host_req(host_req));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reads bytes and compares them with the model queue
    task automatic drain(input logic [3:0] addr, input int n);
        repeat (n) begin
            host_u.rd_byte(addr, q);
            chk("read_data", {8'h00, q}, 16'(exp_q.pop_front()));
        end
    endtask
    // Falling edges on one count clock input, last one registered on return
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(negedge clock);
            count_clock[k] = 1'b1;
            @(negedge clock);
            count_clock[k] = 1'b0;
        end
        @(negedge clock);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Watchdog so a stuck handshake still reaches the verdict
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("Error watchdog expected done seen hang");
        finish_test();
    end
    initial begin
        reset = 1'b1;
        register_group_select = 1'b0;
        count_clock = 3'h0;
        count_gate = 3'h0;
        seed = 32'h17E4A5DB;
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        // Half-written word abandoned by a fresh command
        host_u.command(2'h0, CDAP_ACC_BOTH, 4'h0);
        host_u.wr_byte(CDAP_OFF_CNT1, 8'hAA);
        host_u.command(2'h0, CDAP_ACC_BOTH, 4'h0);
        host_u.wr_word(CDAP_OFF_CNT1, 16'h1234);
        host_u.command(2'h0, CDAP_ACC_LATCH, 4'h0);
        exp_q = '{8'h34, 8'h12};
        // Counter runs three steps while the first latch is unread
        count_gate[0] = 1'b1;
        pulse(0, 3);
        count_gate[0] = 1'b0;
        host_u.command(2'h0, CDAP_ACC_LATCH, 4'h0);
        drain(CDAP_OFF_CNT1, 2);
        host_u.command(2'h0, CDAP_ACC_LATCH, 4'h0);
        host_u.rd_byte(CDAP_OFF_CNT1, w[7:0]);
        host_u.rd_byte(CDAP_OFF_CNT1, w[15:8]);
        chk("fresh_latch", w, 16'h1234 - 16'h0003);
        $display("test latch_hold done");
        seed = xs(seed);
        w = seed[15:0];
        host_u.command(2'h1, CDAP_ACC_BOTH, 4'h0);
        host_u.wr_word(CDAP_OFF_CNT2, w);
        exp_q = '{w[7:0], w[15:8]};
        drain(CDAP_OFF_CNT2, 2);
        // Count latched before the status read-back
        host_u.command(2'h1, CDAP_ACC_LATCH, 4'h0);
        host_u.wr_byte(CDAP_OFF_CMD, 8'hE4);
        host_u.rd_byte(CDAP_OFF_CNT2, q);
        chk("status", {8'h00, q & 8'h7F}, 16'h0030);
        exp_q = '{w[7:0], w[15:8]};
        drain(CDAP_OFF_CNT2, 2);
        $display("test readback done");
        // Single-byte modes; writes with group select high are dropped
        for (int m = 0; m < 4; m++) begin
            seed = xs(seed);
            host_u.command(2'(m & 1), (m < 2) ? CDAP_ACC_LSB : CDAP_ACC_MSB, 4'h0);
            host_u.wr_byte(4'(CDAP_OFF_CNT1 + (m & 1)), seed[7:0]);
            register_group_select = 1'b1;
            host_u.wr_byte(4'(CDAP_OFF_CNT1 + (m & 1)), ~seed[7:0]);
            register_group_select = 1'b0;
            exp_q = '{seed[7:0]};
            drain(4'(CDAP_OFF_CNT1 + (m & 1)), 1);
        end
        $display("test byte_modes done");
        // BCD step, then terminal pulse on counter two
        host_u.wr_byte(CDAP_OFF_CMD, 8'h51);
        host_u.wr_byte(CDAP_OFF_CNT2, 8'h10);
        count_gate = 3'h2;
        pulse(1, 1);
        exp_q = '{8'h09};
        drain(CDAP_OFF_CNT2, 1);
        host_u.wr_byte(CDAP_OFF_CNT2, 8'h01);
        pulse(1, 1);
        chk("update_two", {15'h0000, update_two}, 16'h0001);
        chk("counter_out", {13'h0000, counter_out}, 16'h0002);
        // Counter three output clocks counter one
        host_u.wr_byte(CDAP_OFF_CMD, 8'h90);
        host_u.wr_byte(CDAP_OFF_CNT3, 8'h02);
        host_u.wr_byte(CDAP_OFF_CMD, 8'h18);
        host_u.wr_byte(CDAP_OFF_CNT1, 8'h05);
        count_gate = 3'h5;
        pulse(2, 3);
        exp_q = '{8'h04};
        drain(CDAP_OFF_CNT1, 1);
        chk("update_one", {15'h0000, update_one}, 16'h0000);
        count_gate = 3'h0;
        $display("test count_clocks done");
        finish_test();
    end
endmodule
`default_nettype wire
